// file: bsq_sram_port.sv
// Write-beat FIFO and the burst-of-four separate-port memory core
`timescale 1ns/1ps

// Small synchronous FIFO, first-word visible on the output
module bsq_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic cke,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] store [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;

    // Extra pointer bit tells full from empty
    assign in_ready = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
    assign out_valid = (wp != rp);
    assign out_data = store[rp[AW-1:0]];

    // Pointers
    always_ff @(posedge clk) begin
        if (rst) begin
            wp <= '0;
            rp <= '0;
        end else if (cke) begin
            if (in_valid && in_ready) begin
                wp <= wp + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp <= rp + 1'b1;
            end
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk) begin
        if (cke && in_valid && in_ready) begin
            store[wp[AW-1:0]] <= in_data;
        end
    end
endmodule

// Memory core with DDR write and read ports sampled from the main clock
module bsq_sram_port
    import bsq_pkg::*;
#(
    parameter bit ORG_X36 = 1'b1,
    parameter int FIFO_DEPTH = WBUF_DEPTH
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic cke,
    // Link clocks and loop control
    input wire logic in_clk_true,
    input wire logic in_clk_comp,
    input wire logic out_clk_true,
    input wire logic out_clk_comp,
    input wire logic delay_loop_disable_n,
    // Commands
    input wire logic read_cmd_n,
    input wire logic write_cmd_n,
    input wire logic [ADDR_MAX_W-1:0] addr_in,
    // Write port
    input wire logic [DATA_MAX_W-1:0] write_data_in,
    input wire logic [LANES_MAX-1:0] byte_write_en_n,
    // Read port
    output logic [DATA_MAX_W-1:0] read_data_out,
    output logic read_data_valid,
    output logic echo_clock_true,
    output logic echo_clock_comp,
    // Status
    output logic write_buffer_ready
);
    localparam int AW = ORG_X36 ? ADDR_X36_W : ADDR_X18_W;
    localparam logic [LANES_MAX-1:0] LANE_USE = ORG_X36 ? LANES_X36 : LANES_X18;
    localparam logic [DATA_MAX_W-1:0] DATA_USE = ORG_X36 ? DATA_X36 : DATA_X18;

    // Byte-lane merge, shared by drain and read forwarding
    function automatic logic [DATA_MAX_W-1:0] lane_merge(
        input logic [DATA_MAX_W-1:0] old_w,
        input logic [DATA_MAX_W-1:0] new_w,
        input logic [LANES_MAX-1:0] be_n);
        logic [DATA_MAX_W-1:0] r;
        r = old_w;
        for (int i = 0; i < LANES_MAX; i++) begin
            if (!be_n[i]) begin
                r[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
            end
        end
        return r;
    endfunction

    bsq_pins_type pin_raw;
    bsq_pins_type pin_s1;
    bsq_pins_type pin_s2;
    logic [3:0] clk_prev;
    logic k_rise;
    logic kc_rise;
    logic tied;
    logic ot;
    logic oc;
    logic ot_prev;
    logic oc_prev;
    logic out_true_rise;
    logic out_edge;
    logic dll_on;
    logic last_rd;
    logic rd_take;
    logic wr_take;
    bsq_rd_slot_type rd_new;
    bsq_rd_slot_type next_slot0;
    bsq_rd_slot_type stage [RD_STAGES];
    logic fetch;
    logic [BEAT_W-1:0] fetch_beat;
    logic [ADDR_MAX_W-1:0] fetch_addr;
    logic [BEAT_W-1:0] rd_beat;
    bsq_wr_state_type wstate;
    logic [ADDR_MAX_W-1:0] wbuf_addr;
    logic [DATA_MAX_W-1:0] wbuf_data [BURST_LEN];
    logic [LANES_MAX-1:0] wbuf_be_n [BURST_LEN];
    logic [BURST_LEN-1:0] wbuf_got;
    logic wr_queued;
    logic [ADDR_MAX_W-1:0] wr_queued_addr;
    logic cap;
    logic [BEAT_W-1:0] cap_beat;
    bsq_beat_type push_beat;
    bsq_beat_type drain_beat;
    logic drain_valid;
    logic [DATA_MAX_W-1:0] mem [2**(AW+BEAT_W)];
    logic [DATA_MAX_W-1:0] fetch_word;

    assign pin_raw = {in_clk_true, in_clk_comp, out_clk_true, out_clk_comp,
        delay_loop_disable_n, read_cmd_n, write_cmd_n, addr_in, write_data_in,
        byte_write_en_n};

    // Two-flop synchroniser for every pin, clocks kept in step with data
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            clk_prev <= '0;
        end else if (cke) begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            clk_prev <= {pin_s2.k, pin_s2.kc, pin_s2.c, pin_s2.cc};
        end
    end

    // Edge finding; outputs time from K pair when both output clocks sit high
    assign k_rise = cke && pin_s2.k && !clk_prev[3];
    assign kc_rise = cke && pin_s2.kc && !clk_prev[2];
    assign tied = pin_s2.c && pin_s2.cc;
    assign ot = tied ? pin_s2.k : pin_s2.c;
    assign oc = tied ? pin_s2.kc : pin_s2.cc;
    assign ot_prev = tied ? clk_prev[3] : clk_prev[1];
    assign oc_prev = tied ? clk_prev[2] : clk_prev[0];
    assign out_true_rise = cke && ot && !ot_prev;
    assign out_edge = out_true_rise || (cke && oc && !oc_prev);
    assign dll_on = pin_s2.dloop_n;

    // Command acceptance; address only looked at when a strobe is low
    assign rd_take = k_rise && !pin_s2.rd_n && (pin_s2.wr_n || !last_rd);
    assign wr_take = k_rise && !pin_s2.wr_n && (pin_s2.rd_n || last_rd)
        && (wstate == WR_IDLE || wstate == WR_BEAT3);

    // Which command went last, so a double request takes turns
    always_ff @(posedge clk) begin
        if (rst) begin
            last_rd <= 1'b0;
        end else if (rd_take || wr_take) begin
            last_rd <= rd_take;
        end
    end

    // Read command waits here until the next output-clock edge
    assign next_slot0 = rd_take ? bsq_rd_slot_type'{valid: 1'b1, addr: pin_s2.addr} : rd_new;
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_new <= '0;
        end else if (out_edge) begin
            rd_new <= '0;
        end else if (rd_take) begin
            rd_new <= '{valid: 1'b1, addr: pin_s2.addr};
        end
    end

    // Half-cycle pipeline, one step per output-clock rising edge
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < RD_STAGES; i++) begin
                stage[i] <= '0;
            end
        end else if (out_edge) begin
            stage[0] <= next_slot0;
            for (int i = 1; i < RD_STAGES; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    // Pick the beat due at this edge; bursts are spaced so at most one is due
    always_comb begin
        fetch = 1'b0;
        fetch_beat = '0;
        fetch_addr = '0;
        for (int b = 0; b < BURST_LEN; b++) begin
            if (dll_on && stage[RD_HALF_DLL - 1 + b].valid) begin
                fetch = out_edge;
                fetch_beat = BEAT_W'(b);
                fetch_addr = stage[RD_HALF_DLL - 1 + b].addr;
            end else if (!dll_on && stage[RD_HALF_BYP - 1 + b].valid) begin
                fetch = out_edge;
                fetch_beat = BEAT_W'(b);
                fetch_addr = stage[RD_HALF_BYP - 1 + b].addr;
            end
        end
    end

    // Array word, overlaid by beats 1 to 3 of the write still in the buffer; beat 4 never sets wbuf_got
    always_comb begin
        fetch_word = mem[{fetch_addr[AW-1:0], fetch_beat}];
        if (wstate != WR_IDLE && wbuf_addr == fetch_addr && wbuf_got[fetch_beat]) begin
            fetch_word = lane_merge(fetch_word, wbuf_data[fetch_beat],
                wbuf_be_n[fetch_beat]);
        end
    end

    // Read port registers; a fetch holds off the FIFO drain, so array writes wait for it
    always_ff @(posedge clk) begin
        if (rst) begin
            read_data_out <= '0;
            read_data_valid <= 1'b0;
            rd_beat <= '0;
        end else if (fetch) begin
            read_data_out <= fetch_word & DATA_USE;
            read_data_valid <= 1'b1;
            rd_beat <= fetch_beat;
        end else if (out_edge) begin
            read_data_valid <= 1'b0;
        end
    end

    // Echo clocks copy the timing clock with the same delay as the data
    always_ff @(posedge clk) begin
        if (rst) begin
            echo_clock_true <= 1'b0;
            echo_clock_comp <= 1'b0;
        end else if (cke) begin
            echo_clock_true <= ot;
            echo_clock_comp <= oc;
        end
    end

    // Beat capture: K edges take beats 1 and 3, K# edges take 2 and 4
    assign cap = (wstate == WR_BEAT1 && k_rise) || (wstate == WR_BEAT2 && kc_rise)
        || (wstate == WR_BEAT3 && k_rise) || (wstate == WR_BEAT4 && kc_rise);
    assign cap_beat = (wstate == WR_BEAT1) ? 2'h0 : (wstate == WR_BEAT2) ? 2'h1
        : (wstate == WR_BEAT3) ? 2'h2 : 2'h3;

    // Write sequencer: command, then four beats over two cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            wstate <= WR_IDLE;
            wbuf_addr <= '0;
            wbuf_got <= '0;
            wr_queued <= 1'b0;
            wr_queued_addr <= '0;
        end else if (cke) begin
            case (wstate)
                WR_IDLE: begin
                    if (wr_take) begin
                        wstate <= WR_BEAT1;
                        wbuf_addr <= pin_s2.addr;
                        wbuf_got <= '0;
                    end
                end
                WR_BEAT1: begin
                    if (k_rise) begin
                        wstate <= WR_BEAT2;
                    end
                end
                WR_BEAT2: begin
                    if (kc_rise) begin
                        wstate <= WR_BEAT3;
                    end
                end
                WR_BEAT3: begin
                    if (k_rise) begin
                        wstate <= WR_BEAT4;
                        wr_queued <= wr_take;
                        wr_queued_addr <= pin_s2.addr;
                    end
                end
                WR_BEAT4: begin
                    if (kc_rise) begin
                        wstate <= wr_queued ? WR_BEAT1 : WR_IDLE;
                        wbuf_addr <= wr_queued_addr;
                        wbuf_got <= '0;
                        wr_queued <= 1'b0;
                    end
                end
                default: begin
                    wstate <= WR_IDLE;
                end
            endcase
            if (cap && !(wstate == WR_BEAT4)) begin
                wbuf_got[cap_beat] <= 1'b1;
            end
        end
    end

    // Beat data and enables held for forwarding until the burst ends
    always_ff @(posedge clk) begin
        if (cap) begin
            wbuf_data[cap_beat] <= pin_s2.wdata & DATA_USE;
            wbuf_be_n[cap_beat] <= pin_s2.be_n | ~LANE_USE;
        end
    end

    assign push_beat = '{idx: IDX_W'({wbuf_addr[AW-1:0], cap_beat}),
        data: pin_s2.wdata & DATA_USE, be_n: pin_s2.be_n | ~LANE_USE};

    // Beats queue for the array; the array port yields to read fetches
    bsq_fifo #(
        .W($bits(bsq_beat_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_wfifo (
        .clk(clk),
        .rst(rst),
        .cke(cke),
        .in_valid(cap),
        .in_ready(write_buffer_ready),
        .in_data(push_beat),
        .out_valid(drain_valid),
        .out_ready(!fetch),
        .out_data(drain_beat)
    );

    // Array update, masked per byte lane
    always_ff @(posedge clk) begin
        if (cke && drain_valid && !fetch) begin
            mem[drain_beat.idx[AW+1:0]] <= lane_merge(mem[drain_beat.idx[AW+1:0]],
                drain_beat.data, drain_beat.be_n);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    cmd_turns_a: assert property (!(rd_take && wr_take))
        else $error("read and write taken on one edge");
    read_capture_a: assert property (rd_take |=> ($past(out_edge) ? stage[0].valid
        && stage[0].addr == $past(pin_s2.addr) : rd_new.valid
        && rd_new.addr == $past(pin_s2.addr)))
        else $error("read address not registered");
    beat1_capture_a: assert property (wstate == WR_BEAT1 && k_rise |=> wbuf_got[0]
        && wbuf_data[0] == ($past(pin_s2.wdata) & DATA_USE))
        else $error("write beat 1 not taken on K");
    beat2_capture_a: assert property (wstate == WR_BEAT2 && kc_rise |=> wstate == WR_BEAT3
        && wbuf_got[1])
        else $error("write beat 2 not taken on K#");
    write_start_a: assert property (wstate == WR_IDLE && wr_take |=> wstate == WR_BEAT1
        && wbuf_got == 4'h0)
        else $error("write did not wait for first beat");
    dll_latency_a: assert property (dll_on && out_edge && stage[RD_HALF_DLL-1].valid
        |=> read_data_valid && rd_beat == 2'h0)
        else $error("first read beat late with loop on");
    bypass_latency_a: assert property (!dll_on && out_edge && stage[RD_HALF_BYP-1].valid
        |=> read_data_valid && rd_beat == 2'h0)
        else $error("first read beat late with loop off");
    tied_timing_a: assert property (tied |-> out_edge == (k_rise || kc_rise))
        else $error("output timing not from K when tied");
    echo_align_a: assert property (fetch |=> $rose(echo_clock_true)
        || $rose(echo_clock_comp))
        else $error("echo clock out of step with data");
    idle_cmd_a: assert property (k_rise && pin_s2.rd_n && pin_s2.wr_n && !rd_new.valid
        && wstate == WR_IDLE |=> !rd_new.valid && wstate == WR_IDLE
        && (!$past(out_edge) || !stage[0].valid))
        else $error("operation started without strobe");

    last_beat_c: cover property (fetch && fetch_beat == 2'h3);
    write_done_c: cover property (wstate == WR_BEAT4 && kc_rise);
    concurrent_c: cover property (fetch && cap);
    tied_read_c: cover property (tied && fetch);
endmodule

// file: bsq_pkg.sv
// Shared constants, carrier types and states for the burst-of-four separate-port memory
package bsq_pkg;
    localparam int DATA_MAX_W = 36;
    localparam int BYTE_W = 9;
    localparam int LANES_MAX = 4;
    localparam int ADDR_MAX_W = 19;
    localparam int ADDR_X36_W = 18;
    localparam int ADDR_X18_W = 19;
    localparam int BEAT_W = 2;
    localparam int BURST_LEN = 4;
    localparam int IDX_W = ADDR_MAX_W + BEAT_W;
    localparam logic [LANES_MAX-1:0] LANES_X36 = 4'hF;
    localparam logic [LANES_MAX-1:0] LANES_X18 = 4'h3;
    localparam logic [DATA_MAX_W-1:0] DATA_X36 = 36'hF_FFFF_FFFF;
    localparam logic [DATA_MAX_W-1:0] DATA_X18 = 36'h0_0003_FFFF;
    // Read latency in output half-cycles: 1.5 cycles with the loop, 1.0 without
    localparam int RD_HALF_DLL = 3;
    localparam int RD_HALF_BYP = 2;
    localparam int RD_STAGES = 6;
    localparam int WBUF_DEPTH = 8;

    typedef struct packed {
        logic k;
        logic kc;
        logic c;
        logic cc;
        logic dloop_n;
        logic rd_n;
        logic wr_n;
        logic [ADDR_MAX_W-1:0] addr;
        logic [DATA_MAX_W-1:0] wdata;
        logic [LANES_MAX-1:0] be_n;
    } bsq_pins_type;

    typedef struct packed {
        logic [IDX_W-1:0] idx;
        logic [DATA_MAX_W-1:0] data;
        logic [LANES_MAX-1:0] be_n;
    } bsq_beat_type;

    typedef struct packed {
        logic valid;
        logic [ADDR_MAX_W-1:0] addr;
    } bsq_rd_slot_type;

    typedef enum logic [2:0] {WR_IDLE, WR_BEAT1, WR_BEAT2, WR_BEAT3, WR_BEAT4} bsq_wr_state_type;
endpackage

// file: bsq_ctrl_model.sv
// Controller model: link clock pairs, command slots and write beats
`timescale 1ns/1ps
module bsq_ctrl_model
    import bsq_pkg::*;
(
    // Mode from the bench
    input wire logic tie_c,
    input wire logic loop_on,
    // Pins toward the memory
    output bsq_pins_type pins
);
    logic [ADDR_MAX_W+1:0] cq[$];
    logic [3:0][DATA_MAX_W-1:0] dq[$];
    logic [3:0][LANES_MAX-1:0] bq[$];
    logic [DATA_MAX_W-1:0] sd [8];
    logic [LANES_MAX-1:0] sb [8];
    logic sv [8];
    logic [ADDR_MAX_W+1:0] cmd;
    logic [3:0][DATA_MAX_W-1:0] d;
    logic [3:0][LANES_MAX-1:0] b;
    int h;

    // Queue one K-cycle slot as {read_n, write_n, addr}; idle slots keep spacing
    task automatic push(input logic [ADDR_MAX_W+1:0] c, input logic [3:0][DATA_MAX_W-1:0] dd,
                        input logic [3:0][LANES_MAX-1:0] bb);
        cq.push_back(c);
        dq.push_back(dd);
        bq.push_back(bb);
    endtask

    // Pins move 50 ns before each edge, so setup and hold are equal
    initial begin
        pins = '0;
        pins.rd_n = 1'b1;
        pins.wr_n = 1'b1;
        pins.kc = 1'b1;
        sv = '{default: 1'b0};
        h = 0;
        #3;
        forever begin
            #50;
            pins.dloop_n = loop_on;
            cmd = {2'b11, ~pins.addr};
            if (h[0] == 1'b0 && cq.size() > 0) begin
                cmd = cq.pop_front();
                d = dq.pop_front();
                b = bq.pop_front();
                for (int i = 0; i < 4 && !cmd[ADDR_MAX_W]; i++) begin
                    sd[(h + 2 + i) % 8] = d[i];
                    sb[(h + 2 + i) % 8] = b[i];
                    sv[(h + 2 + i) % 8] = 1'b1;
                end
            end
            {pins.rd_n, pins.wr_n, pins.addr} = cmd;
            // Outside a burst the data lines keep moving so stale values never match
            pins.wdata = sv[h % 8] ? sd[h % 8] : ~pins.wdata;
            pins.be_n = sv[h % 8] ? sb[h % 8] : LANES_MAX'($urandom);
            sv[h % 8] = 1'b0;
            #50;
            pins.k = ~h[0];
            pins.kc = h[0];
            pins.c = tie_c | ~h[0];
            pins.cc = tie_c | h[0];
            h++;
        end
    end
endmodule

// file: burst4_sep_io_ddr_sram_port_bench.sv
// Self-checking bench: bursts through the controller model, enable freeze, buffer status
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module burst4_sep_io_ddr_sram_port_bench import bsq_pkg::*;;
    logic clk, rst, cke, tie_c, loop_on;
    bsq_pins_type pins;
    logic [DATA_MAX_W-1:0] read_data_out;
    logic read_data_valid, echo_clock_true, echo_clock_comp, write_buffer_ready;
    logic [DATA_MAX_W-1:0] mem [int];
    logic [3:0][DATA_MAX_W-1:0] expq[$];
    logic [ADDR_MAX_W-1:0] pool [4];
    int fails, checks;

    bsq_ctrl_model ctrl (.tie_c(tie_c), .loop_on(loop_on), .pins(pins));
    bsq_sram_port uut (.clk(clk), .rst(rst), .cke(cke), .in_clk_true(pins.k),
        .in_clk_comp(pins.kc), .out_clk_true(pins.c), .out_clk_comp(pins.cc),
        .delay_loop_disable_n(pins.dloop_n), .read_cmd_n(pins.rd_n), .write_cmd_n(pins.wr_n),
        .addr_in(pins.addr), .write_data_in(pins.wdata), .byte_write_en_n(pins.be_n),
        .read_data_out(read_data_out), .read_data_valid(read_data_valid),
        .echo_clock_true(echo_clock_true), .echo_clock_comp(echo_clock_comp),
        .write_buffer_ready(write_buffer_ready));

    // 40 MHz main clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // A low enable lets its 9-bit lane through
    function automatic logic [DATA_MAX_W-1:0] lane_mix(input logic [DATA_MAX_W-1:0] o, n,
                                                        input logic [LANES_MAX-1:0] be);
        for (int i = 0; i < LANES_MAX; i++)
            if (!be[i]) o[i*BYTE_W +: BYTE_W] = n[i*BYTE_W +: BYTE_W];
        return o;
    endfunction

    // One K-cycle slot: 0 idle, 1 write, 2 read, 3 full write
    task automatic slot(input int k, input logic [ADDR_MAX_W-1:0] a);
        logic [3:0][DATA_MAX_W-1:0] d, e;
        logic [3:0][LANES_MAX-1:0] b;
        int ix;
        for (int i = 0; i < 4; i++) begin
            ix = {a, 2'(i)};
            d[i] = {4'($urandom), 32'($urandom)};
            b[i] = (k == 3) ? '0 : LANES_MAX'($urandom);
            if (k == 1 || k == 3)
                mem[ix] = lane_mix(mem.exists(ix) ? mem[ix] : '0, d[i], b[i]);
            e[i] = mem.exists(ix) ? mem[ix] : '0;
        end
        if (k == 2)
            expq.push_back(e);
        ctrl.push({k != 2, k != 1 && k != 3, a}, d, b);
    endtask

    // Beats sampled late in the window, 150 ns after each output edge
    task automatic check_burst(input logic [3:0][DATA_MAX_W-1:0] e, input int lat);
        #(lat * 100 + 150);
        for (int i = 0; i < 4; i++) begin
            `CHK(read_data_out, e[i])
            `CHK(read_data_valid, 1'b1)
            `CHK({echo_clock_true, echo_clock_comp}, {~1'(lat + i), 1'(lat + i)})
            `CHK(write_buffer_ready, 1'b1)
            #100;
        end
    endtask

    // Each read taken at a K rise owes four beats after the mode's latency
    always @(posedge pins.k) begin
        if (!pins.rd_n && !rst) fork
            check_burst(expq.pop_front(), loop_on ? 3 : 2);
        join_none
    end

    task results();
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard, well beyond the planned traffic
    initial begin
        #200_000;
        fails++;
        results();
    end

    // Main sequence: reset, enable freeze, then three timing modes of mixed traffic
    initial begin
        logic [ADDR_MAX_W-1:0] a;
        logic [1:0] ebits;
        fails = 0;
        checks = 0;
        rst = 1'b1;
        cke = 1'b1;
        tie_c = 1'b0;
        loop_on = 1'b1;
        void'($urandom(54256));
        for (int i = 0; i < 4; i++)
            pool[i] = {1'b0, 18'($urandom)};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK({read_data_out, read_data_valid, echo_clock_true, echo_clock_comp}, '0)
        `CHK(write_buffer_ready, 1'b1)
        // Enable low freezes the core: 300 ns spans three K toggles, so a live echo would move
        repeat (8) @(posedge clk);
        cke <= 1'b0;
        @(posedge clk);
        #1;
        ebits = {echo_clock_true, echo_clock_comp};
        repeat (12) @(posedge clk);
        #1;
        `CHK({echo_clock_true, echo_clock_comp}, ebits)
        `CHK(read_data_valid, 1'b0)
        `CHK(write_buffer_ready, 1'b1)
        cke <= 1'b1;
        // Let the synchronisers refill before any command reaches the pins
        repeat (6) @(posedge clk);
        #1;
        `CHK(write_buffer_ready, 1'b1)
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            tie_c <= (m == 1);
            loop_on <= (m != 2);
            // Write then read the same address in the next slot: forwarding case
            for (int i = 0; i < 4; i++) begin
                slot(3, pool[i]);
                slot(2, pool[i]);
            end
            for (int i = 0; i < 12; i++) begin
                a = pool[$urandom_range(0, 3)];
                slot($urandom_range(0, 3) == 0 ? 0 : 1, a);
                slot($urandom_range(0, 3) == 0 ? 0 : 2, $urandom_range(0, 1) ? a : pool[i % 4]);
            end
            while (ctrl.cq.size() != 0)
                @(posedge clk);
            #1200;
            `CHK(read_data_valid, 1'b0)
            `CHK(write_buffer_ready, 1'b1)
        end
        results();
    end
endmodule
